/* gpic_top.sv */
// Purpose: Grouped four-level interrupt controller with vectoring and bank stacking
// Assumes: All request and event inputs come from logic on clk_i
// Notes:   Enable registers and the main status flags live outside this block
`timescale 1ns/1ps
`include "gpic_regs.svh"

// Summary of operation
// RULE1 - Twenty-four source positions sorted into groups
// RULE2 - Group is source bit position in enable register
// RULE3 - Group level from high and low priority registers
// RULE4 - Bit pair selects level zero to three
// RULE5 - Priority bits seven and six read zero
// RULE6 - Only strictly higher level preempts running service
// RULE7 - Higher level wins among simultaneous requests
// RULE8 - Equal or lower level never interrupts service
// RULE9 - Same level ties follow fixed scan order
// RULE10 - Service is a long call to vector
// RULE11 - Vectors eight bytes apart with fixed gap
// RULE12 - Channel change flag set by hardware, software clears
// RULE13 - Converter wake-up flag set by hardware, software clears
// RULE14 - Extra external flags set by pin events
// RULE15 - Entry writes bank register to stack, increments
// RULE16 - After save, interrupt bank copied into both fields
// RULE17 - Return decrements, reads stack into bank register
// RULE18 - Latched flags stay pending until software clears
// RULE19 - Return clears only the highest active level
// RULE20 - Only enabled, implemented sources take part
module gpic_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Special function register port
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   output logic [7:0]       sfr_rdata_o,
   // Enable registers held in the core
   input  wire logic [7:0]  enable_reg_a_i,
   input  wire logic [7:0]  enable_reg_b_i,
   input  wire logic [7:0]  enable_reg_c_i,
   input  wire logic [7:0]  enable_reg_d_i,
   // Request flags of the other sources, by source index
   input  wire logic [23:0] src_req_i,
   // Events for the extra status register
   input  wire logic        channel_change_evt_i,
   input  wire logic        converter_wakeup_evt_i,
   input  wire logic        extra_ext0_evt_i,
   input  wire logic        extra_ext1_evt_i,
   // Core handshake
   output logic             irq_req_o,
   output logic [15:0]      irq_vector_o,
   output logic [1:0]       irq_level_o,
   output logic [4:0]       irq_source_o,
   input  wire logic        irq_ack_i,
   input  wire logic        return_from_interrupt_instr_i,
   output logic [3:0]       active_levels_o,
   // Memory extension
   input  wire logic [3:0]  interrupt_bank_i,
   output logic [7:0]       current_bank_reg_o,
   output logic [7:0]       bank_stack_pointer_o,
   output logic             bank_busy_o,
   // External stack memory
   output logic [7:0]       stack_address_bus_o,
   output logic [7:0]       stack_data_out_o,
   output logic             stack_write_o,
   output logic             stack_read_o,
   input  wire logic [7:0]  stack_data_in_i
);
   import gpic_pkg::*;

   logic [1:0]   rst_sync_reg;
   logic         rst_n;
   gpic_top_type st_reg;
   gpic_top_type st_next;
   gpic_arb_type arb;
   logic [23:0]  enables;
   logic [23:0]  owned;
   logic [23:0]  pending;
   logic [23:0]  eligible;
   logic         allowed;
   logic         take;
   logic         leave;
   logic [3:0]   set_evt;
   logic [3:0]   top_active;

   // Release of reset is synchronised, assertion stays asynchronous
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Priority levels and the highest active level
   function automatic logic lvl_above_active(input logic [1:0] lvl, input logic [3:0] act);
      return ((act >> lvl) == 4'h0);
   endfunction

   function automatic logic [3:0] highest_bit(input logic [3:0] act);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (act[i]) begin
            r = 4'(1 << i);
         end
      end
      return r;
   endfunction

   // Map the extra status flags onto their source positions
   always_comb begin
      owned                   = 24'h000000;
      owned[`GPIC_SRC_EXT0]   = st_reg.xstat[`GPIC_XS_EXT0];
      owned[`GPIC_SRC_EXT1]   = st_reg.xstat[`GPIC_XS_EXT1];
      owned[`GPIC_SRC_CHANNEL] = st_reg.xstat[`GPIC_XS_CHANNEL_CHANGE];
      owned[`GPIC_SRC_WAKEUP] = st_reg.xstat[`GPIC_XS_WAKEUP];
   end

   assign enables  = {enable_reg_d_i[5:0], enable_reg_c_i[5:0],
                      enable_reg_b_i[5:0], enable_reg_a_i[5:0]};
   // Flags are levels held until cleared, so a late poll still sees them
   assign pending  = (src_req_i & ~`GPIC_OWNED_MASK) | owned; // RULE18
   assign eligible = pending & enables & ~`GPIC_UNIMPL_MASK; // RULE20

   gpic_arbiter u_arbiter (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n),
      .req_i       (eligible),
      .prio_high_i (st_reg.prio_high),
      .prio_low_i  (st_reg.prio_low),
      .arb_o       (arb)
   );

   // Arbiter picks the top level, so testing only that level is enough
   assign allowed   = lvl_above_active(arb.level, st_reg.active); // RULE6 RULE8
   // Withheld while the bank unit is busy, so stack traffic never overlaps;
   // a stale pick whose flag was just cleared is dropped, and a return is never lost to a same-cycle acknowledge
   assign irq_req_o = arb.valid && eligible[arb.idx] && allowed && !bank_busy_o // RULE20
                      && !sfr_wr_i && !return_from_interrupt_instr_i;
   assign take      = irq_req_o && irq_ack_i;
   assign leave     = return_from_interrupt_instr_i && !bank_busy_o && !take;
   assign top_active = highest_bit(st_reg.active);

   assign set_evt = {channel_change_evt_i, converter_wakeup_evt_i,
                     extra_ext1_evt_i, extra_ext0_evt_i};

   always_comb begin
      st_next = st_reg;
      // Register writes
      if (sfr_wr_i) begin
         if (sfr_addr_i == `GPIC_OFS_PRIO_HIGH) begin
            st_next.prio_high = sfr_wdata_i[5:0]; // RULE3
         end else if (sfr_addr_i == `GPIC_OFS_PRIO_LOW) begin
            st_next.prio_low = sfr_wdata_i[5:0]; // RULE3
         end else if (sfr_addr_i == `GPIC_OFS_EXTRA_STATUS) begin
            st_next.xstat = sfr_wdata_i & `GPIC_XS_IMPL_MASK;
         end
      end
      // Hardware set wins over a software clear in the same cycle
      if (set_evt[3]) begin
         st_next.xstat[`GPIC_XS_CHANNEL_CHANGE] = 1'b1; // RULE12
      end
      if (set_evt[2]) begin
         st_next.xstat[`GPIC_XS_WAKEUP] = 1'b1; // RULE13
      end
      if (set_evt[1]) begin
         st_next.xstat[`GPIC_XS_EXT1] = 1'b1; // RULE14
      end
      if (set_evt[0]) begin
         st_next.xstat[`GPIC_XS_EXT0] = 1'b1; // RULE14
      end
      // Level-active flags
      if (take) begin
         st_next.active = st_reg.active | 4'(1 << arb.level); // RULE6
      end else if (leave) begin
         st_next.active = st_reg.active & ~top_active; // RULE19
      end
      // Register reads, unused bits and unmapped addresses give zero
      if (sfr_rd_i) begin
         if (sfr_addr_i == `GPIC_OFS_PRIO_HIGH) begin
            st_next.rdata = {2'b00, st_reg.prio_high}; // RULE5
         end else if (sfr_addr_i == `GPIC_OFS_PRIO_LOW) begin
            st_next.rdata = {2'b00, st_reg.prio_low}; // RULE5
         end else if (sfr_addr_i == `GPIC_OFS_EXTRA_STATUS) begin
            st_next.rdata = st_reg.xstat;
         end else begin
            st_next.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg           <= '0;
         st_reg.prio_high <= `GPIC_RST_PRIO;
         st_reg.prio_low  <= `GPIC_RST_PRIO;
         st_reg.xstat     <= `GPIC_RST_STATUS;
      end else begin
         st_reg <= st_next;
      end
   end

   gpic_bank_stack u_bank_stack (
      .clk_i                (clk_i),
      .rst_n_i              (rst_n),
      .save_i               (take),
      .restore_i            (leave),
      .interrupt_bank_i     (interrupt_bank_i),
      .stack_address_o      (stack_address_bus_o),
      .stack_data_out_o     (stack_data_out_o),
      .stack_write_o        (stack_write_o),
      .stack_read_o         (stack_read_o),
      .stack_data_in_i      (stack_data_in_i),
      .current_bank_o       (current_bank_reg_o),
      .bank_stack_pointer_o (bank_stack_pointer_o),
      .busy_o               (bank_busy_o)
   );

   assign irq_vector_o    = arb.vector; // RULE10
   assign irq_level_o     = arb.level;
   assign irq_source_o    = arb.idx;
   assign active_levels_o = st_reg.active;
   assign sfr_rdata_o     = st_reg.rdata;
endmodule

/* gpic_regs.svh */
// Purpose: Offsets, field positions, reset values and constants of the interrupt controller
// Assumes: Included by every design module and by the bench
// Notes:   Definitions only
`ifndef GPIC_REGS_SVH
`define GPIC_REGS_SVH

// Register offsets on the special function register port
`define GPIC_OFS_PRIO_HIGH     8'hAC
`define GPIC_OFS_PRIO_LOW      8'hB8
`define GPIC_OFS_EXTRA_STATUS  8'hC8

// Reset values
`define GPIC_RST_PRIO          6'h00
`define GPIC_RST_STATUS        8'h00
`define GPIC_RST_BANK          8'h00
`define GPIC_RST_SP            8'h00

// Extra status register bit positions
`define GPIC_XS_CHANNEL_CHANGE 7
`define GPIC_XS_WAKEUP         6
`define GPIC_XS_EXT1           1
`define GPIC_XS_EXT0           0
`define GPIC_XS_IMPL_MASK      8'hC3

// Source indices fed by the extra status register
`define GPIC_SRC_EXT0          5'd7
`define GPIC_SRC_EXT1          5'd9
`define GPIC_SRC_CHANNEL       5'd15
`define GPIC_SRC_WAKEUP        5'd23

// Source positions and structure
`define GPIC_NUM_SOURCES       24
`define GPIC_NUM_GROUPS        6
`define GPIC_NUM_REGS          4
`define GPIC_UNIMPL_MASK       24'h3C3040
`define GPIC_OWNED_MASK        24'h808280

// Vector table layout
`define GPIC_VEC_BASE          16'h0003
`define GPIC_VEC_GAP_INDEX     5'd14
`define GPIC_VEC_GAP_SLOTS     6'd2

// Bank register layout
`define GPIC_BANK_NEXT_HI      7
`define GPIC_BANK_NEXT_LO      4
`define GPIC_BANK_CUR_HI       3
`define GPIC_BANK_CUR_LO       0

`endif

/* gpic_pkg.sv */
// Purpose: Types shared by the interrupt controller modules
// Assumes: Constants come from gpic_regs.svh
// Notes:   Each module keeps its state in one packed struct, apart from the reset synchroniser in gpic_top
package gpic_pkg;

   typedef enum logic [2:0] {
      BK_IDLE,
      BK_SAVE,
      BK_RDEC,
      BK_READ,
      BK_LOAD
   } gpic_bank_state_type;

   typedef struct packed {
      gpic_bank_state_type state;
      logic [7:0]          sp;
      logic [7:0]          bank;
      logic [7:0]          addr;
      logic [7:0]          wdata;
      logic                we;
      logic                re;
   } gpic_bank_type;

   typedef struct packed {
      logic                valid;
      logic [4:0]          idx;
      logic [1:0]          level;
      logic [15:0]         vector;
   } gpic_arb_type;

   typedef struct packed {
      logic [5:0]          prio_high;
      logic [5:0]          prio_low;
      logic [7:0]          xstat;
      logic [3:0]          active;
      logic [7:0]          rdata;
   } gpic_top_type;

endpackage

/* gpic_arbiter.sv */
// Purpose: Picks the pending source with the highest level, ties broken by scan order
// Assumes: Requests already masked by enables; one cycle of latency to the result
// Notes:   Result is registered so the vector leaves on flip-flops
`timescale 1ns/1ps
`include "gpic_regs.svh"
module gpic_arbiter (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // Requests and levels
   input  wire logic [23:0]        req_i,
   input  wire logic [5:0]         prio_high_i,
   input  wire logic [5:0]         prio_low_i,
   // Chosen request
   output gpic_pkg::gpic_arb_type  arb_o
);
   import gpic_pkg::*;

   gpic_arb_type arb_reg;
   gpic_arb_type arb_next;

   function automatic logic [2:0] src_group(input logic [4:0] idx);
      return 3'(idx % 5'd6);
   endfunction

   function automatic logic [15:0] src_vector(input logic [4:0] idx);
      logic [5:0] slot;
      slot = (idx < `GPIC_VEC_GAP_INDEX) ? {1'b0, idx} : 6'({1'b0, idx}) + `GPIC_VEC_GAP_SLOTS;
      return `GPIC_VEC_BASE + {7'h00, slot, 3'h0}; // RULE11
   endfunction

   always_comb begin
      logic [4:0] idx;
      logic [2:0] grp;
      logic [1:0] lvl;
      idx = 5'd0;
      grp = 3'd0;
      lvl = 2'd0;
      arb_next = '0;
      // Walk backwards so the earliest scan position wins a tie
      for (int p = `GPIC_NUM_SOURCES - 1; p >= 0; p--) begin
         idx = 5'((p % `GPIC_NUM_REGS) * `GPIC_NUM_GROUPS + p / `GPIC_NUM_REGS); // RULE2
         grp = src_group(idx); // RULE1
         lvl = {prio_high_i[grp], prio_low_i[grp]}; // RULE3 RULE4
         if (req_i[idx] && (!arb_next.valid || lvl >= arb_next.level)) begin // RULE7 RULE9
            arb_next.valid = 1'b1;
            arb_next.idx   = idx;
            arb_next.level = lvl;
         end
      end
      arb_next.vector = src_vector(arb_next.idx); // RULE10
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         arb_reg <= '0;
      end else begin
         arb_reg <= arb_next;
      end
   end

   assign arb_o = arb_reg;
endmodule

/* gpic_bank_stack.sv */
// Purpose: Saves the bank register to external stack on entry, restores it on return
// Assumes: Stack memory returns read data in the cycle after it sees the read strobe
// Notes:   Save takes 2 cycles, restore takes 4; requests while busy are ignored
`timescale 1ns/1ps
`include "gpic_regs.svh"
module gpic_bank_stack (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Sequence requests
   input  wire logic       save_i,
   input  wire logic       restore_i,
   input  wire logic [3:0] interrupt_bank_i,
   // External stack memory
   output logic [7:0]      stack_address_o,
   output logic [7:0]      stack_data_out_o,
   output logic            stack_write_o,
   output logic            stack_read_o,
   input  wire logic [7:0] stack_data_in_i,
   // State
   output logic [7:0]      current_bank_o,
   output logic [7:0]      bank_stack_pointer_o,
   output logic            busy_o
);
   import gpic_pkg::*;

   gpic_bank_type st_reg;
   gpic_bank_type st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.we = 1'b0;
      st_next.re = 1'b0;
      case (st_reg.state)
         BK_IDLE: begin
            if (save_i) begin
               st_next.wdata = st_reg.bank; // RULE15
               st_next.addr  = st_reg.sp; // RULE15
               st_next.we    = 1'b1; // RULE15
               st_next.state = BK_SAVE;
            end else if (restore_i) begin
               st_next.sp    = st_reg.sp - 8'h01; // RULE17
               st_next.state = BK_RDEC;
            end
         end
         BK_SAVE: begin
            st_next.sp    = st_reg.sp + 8'h01; // RULE15
            st_next.bank  = {interrupt_bank_i, interrupt_bank_i}; // RULE16
            st_next.state = BK_IDLE;
         end
         BK_RDEC: begin
            st_next.addr  = st_reg.sp; // RULE17
            st_next.re    = 1'b1; // RULE17
            st_next.state = BK_READ;
         end
         BK_READ: begin
            st_next.state = BK_LOAD;
         end
         BK_LOAD: begin
            st_next.bank  = stack_data_in_i; // RULE17
            st_next.state = BK_IDLE;
         end
         default: begin
            st_next.state = BK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg       <= '0;
         st_reg.state <= BK_IDLE;
         st_reg.sp    <= `GPIC_RST_SP;
         st_reg.bank  <= `GPIC_RST_BANK;
      end else begin
         st_reg <= st_next;
      end
   end

   assign stack_address_o      = st_reg.addr;
   assign stack_data_out_o     = st_reg.wdata;
   assign stack_write_o        = st_reg.we;
   assign stack_read_o         = st_reg.re;
   assign current_bank_o       = st_reg.bank;
   assign bank_stack_pointer_o = st_reg.sp;
   assign busy_o               = (st_reg.state != BK_IDLE);
endmodule

/* gpic_top_checker.sv */
// Purpose: Port assertions for the interrupt controller
// Assumes: Bound into gpic_top; one clock domain
// Notes:   Priority register contents are judged by the bench
`timescale 1ns/1ps
module gpic_top_checker (
   // Clock, reset and core handshake
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        irq_req_o,
   input wire logic [15:0] irq_vector_o,
   input wire logic [1:0]  irq_level_o,
   input wire logic [4:0]  irq_source_o,
   input wire logic        irq_ack_i,
   input wire logic        return_from_interrupt_instr_i,
   input wire logic [3:0]  active_levels_o,
   // Bank stacking
   input wire logic [3:0]  interrupt_bank_i,
   input wire logic [7:0]  current_bank_reg_o,
   input wire logic [7:0]  bank_stack_pointer_o,
   input wire logic        bank_busy_o,
   input wire logic [7:0]  stack_address_bus_o,
   input wire logic [7:0]  stack_data_out_o,
   input wire logic        stack_write_o,
   input wire logic        stack_read_o,
   input wire logic [7:0]  stack_data_in_i
);
   logic take;
   assign take = irq_req_o && irq_ack_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   function automatic logic [15:0] vec_of(input logic [4:0] i);
      return 16'h0003 + {8'h00, ((i < 5'h0E) ? i : i + 5'h02), 3'h0};
   endfunction
   property p_vector; irq_req_o |-> irq_vector_o == vec_of(irq_source_o); endproperty
   a_vector: assert property (p_vector) else $error("vector wrong");
   property p_gate; irq_req_o |-> (active_levels_o >> irq_level_o) == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("request not above active");
   property p_enter;
      take |=> active_levels_o == ($past(active_levels_o) | (4'h1 << $past(irq_level_o)));
   endproperty
   a_enter: assert property (p_enter) else $error("level flag not set");
   property p_save;
      take |=> stack_write_o && stack_address_bus_o == $past(bank_stack_pointer_o)
         && stack_data_out_o == $past(current_bank_reg_o);
   endproperty
   a_save: assert property (p_save) else $error("bank save wrong");
   property p_inc;
      stack_write_o |=> bank_stack_pointer_o == $past(bank_stack_pointer_o) + 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("pointer not incremented");
   property p_copy; stack_write_o |=> current_bank_reg_o == {2{$past(interrupt_bank_i)}}; endproperty
   a_copy: assert property (p_copy) else $error("bank copy wrong");
   property p_rdaddr;
      stack_read_o |-> stack_address_bus_o == bank_stack_pointer_o
         && bank_stack_pointer_o == $past(bank_stack_pointer_o, 2) - 8'h01;
   endproperty
   a_rdaddr: assert property (p_rdaddr) else $error("restore address wrong");
   property p_load; stack_read_o |-> ##2 current_bank_reg_o == $past(stack_data_in_i); endproperty
   a_load: assert property (p_load) else $error("restore data wrong");
   // Only the top flag may drop, and the restore read must follow at once
   property p_ret;
      return_from_interrupt_instr_i && !bank_busy_o && !take && active_levels_o != 4'h0
         |=> $onehot($past(active_levels_o) ^ active_levels_o)
         && active_levels_o < ($past(active_levels_o) ^ active_levels_o) ##1 stack_read_o;
   endproperty
   a_ret: assert property (p_ret) else $error("return clear wrong");
   c_take: cover property (take);
   c_nest: cover property (take && active_levels_o != 4'h0);
   c_restore: cover property (stack_read_o);
endmodule

bind gpic_top gpic_top_checker u_checker (.clk_i, .resetn_i, .irq_req_o, .irq_vector_o,
   .irq_level_o, .irq_source_o, .irq_ack_i, .return_from_interrupt_instr_i,
   .active_levels_o, .interrupt_bank_i, .current_bank_reg_o, .bank_stack_pointer_o,
   .bank_busy_o, .stack_address_bus_o, .stack_data_out_o, .stack_write_o, .stack_read_o,
   .stack_data_in_i);

/* gpic_stack_mem.sv */
// Purpose: External bank stack memory
// Assumes: Read data is due in the cycle after the read strobe
// Notes:   Outside that cycle the data toggles so stale data never matches
`timescale 1ns/1ps
module gpic_stack_mem (
   // Clock and stack bus
   input  wire logic       clk_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       write_i,
   input  wire logic       read_i,
   output logic [7:0]      rdata_o
);
   logic [7:0] mem [256];
   initial rdata_o = 8'h00;
   always @(posedge clk_i) begin
      if (write_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= read_i ? mem[addr_i] : ~rdata_o;
   end
endmodule

/* tb_grouped_priority_interrupt_controller.sv */
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Inputs change on the falling edge
// Notes:   Expectations come from bench functions
`timescale 1ns/1ps
`include "gpic_regs.svh"
module tb_grouped_priority_interrupt_controller;
   logic        clk_i, resetn_i, wr, rd, ack, ret, req, busy, swe, sre;
   logic [7:0]  addr, wdat, rdat, bank, sp, sadr, sdo, sdi;
   logic [7:0]  en [4];
   logic [23:0] sreq;
   logic [3:0]  evt, ib, act;
   logic [15:0] vec;
   logic [4:0]  src;
   logic [1:0]  lvl;
   logic [5:0]  hi, lo;
   logic [31:0] rnd;
   int          error_cnt, samples_checked, cyc;
   localparam logic [7:0] xbit [4] = '{8'h80, 8'h40, 8'h01, 8'h02};
   localparam int         xsrc [4] = '{15, 23, 7, 9};

   gpic_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_addr_i(addr), .sfr_wdata_i(wdat),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdat), .enable_reg_a_i(en[0]),
      .enable_reg_b_i(en[1]), .enable_reg_c_i(en[2]), .enable_reg_d_i(en[3]),
      .src_req_i(sreq), .channel_change_evt_i(evt[0]), .converter_wakeup_evt_i(evt[1]),
      .extra_ext0_evt_i(evt[2]), .extra_ext1_evt_i(evt[3]), .irq_req_o(req),
      .irq_vector_o(vec), .irq_level_o(lvl), .irq_source_o(src), .irq_ack_i(ack),
      .return_from_interrupt_instr_i(ret), .active_levels_o(act), .interrupt_bank_i(ib),
      .current_bank_reg_o(bank), .bank_stack_pointer_o(sp), .bank_busy_o(busy),
      .stack_address_bus_o(sadr), .stack_data_out_o(sdo), .stack_write_o(swe),
      .stack_read_o(sre), .stack_data_in_i(sdi));
   gpic_stack_mem u_mem (.clk_i(clk_i), .addr_i(sadr), .wdata_i(sdo), .write_i(swe),
      .read_i(sre), .rdata_o(sdi));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] vexp(input int i);
      return 16'h0003 + 16'(8 * (i < 14 ? i : i + 2));
   endfunction
   // Returns found bit and source; level first, then group, then enable register
   function automatic logic [5:0] pick(input logic [23:0] r);
      for (int l = 3; l >= 0; l--)
         for (int g = 0; g < 6; g++)
            for (int k = 0; k < 4; k++)
               if ({hi[g], lo[g]} == l[1:0] && r[g + 6 * k] && en[k][g])
                  return {1'b1, 5'(g + 6 * k)};
      return 6'h00;
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Write when w is set, otherwise read and compare with d
   task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdat = d;
      wr = w;
      rd = !w;
      @(negedge clk_i);
      wr = 1'b0;
      rd = 1'b0;
      if (!w) chk("register", 16'(d), 16'(rdat));
      @(negedge clk_i);
   endtask
   task automatic arb(input logic [23:0] r);
      logic [5:0] p;
      p = pick(r & ~`GPIC_UNIMPL_MASK);
      repeat (2) @(negedge clk_i);
      chk("request", 16'(p[5]), 16'(req));
      if (p[5]) begin
         chk("source", 16'(p[4:0]), 16'(src));
         chk("vector", vexp(p[4:0]), vec);
         chk("level", 16'({hi[p[4:0] % 6], lo[p[4:0] % 6]}), 16'(lvl));
      end
   endtask
   task automatic serve(input logic [4:0] s);
      int t = 0;
      while (req !== 1'b1 && t < 50) begin
         @(negedge clk_i);
         t++;
      end
      chk("source", 16'(s), 16'(src));
      chk("vector", vexp(s), vec);
      ack = 1'b1;
      @(negedge clk_i);
      ack = 1'b0;
      chk("busy", 16'h0001, 16'(busy));
      repeat (3) @(negedge clk_i);
   endtask
   task automatic leave();
      ret = 1'b1;
      @(negedge clk_i);
      ret = 1'b0;
      chk("busy", 16'h0001, 16'(busy));
      repeat (6) @(negedge clk_i);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Whole run is under 1500 cycles; this ceiling only trips on a hang
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      {resetn_i, wr, rd, ack, ret, evt, ib, addr, wdat, sreq, hi, lo} = '0;
      en = '{default: 8'h00};
      rnd = 32'h299A;
      repeat (8) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (4) @(negedge clk_i);
      sfr(1'b0, 8'hAC, 8'h00);
      sfr(1'b0, 8'hB8, 8'h00);
      sfr(1'b1, 8'hAC, 8'hFF);
      sfr(1'b1, 8'hB8, 8'hFF);
      sfr(1'b1, 8'h3D, 8'hFF);
      sfr(1'b0, 8'hAC, 8'h3F);
      sfr(1'b0, 8'hB8, 8'h3F);
      sfr(1'b0, 8'h3D, 8'h00);
      sfr(1'b1, 8'hC8, 8'hFF);
      sfr(1'b0, 8'hC8, 8'hC3);
      sfr(1'b1, 8'hC8, 8'h00);
      sfr(1'b1, 8'hAC, 8'h00);
      sfr(1'b1, 8'hB8, 8'h00);
      en = '{default: 8'h3F};
      for (int k = 0; k < 4; k++) begin
         evt = 4'(1 << k);
         @(negedge clk_i);
         evt = 4'h0;
         repeat (20) @(negedge clk_i);
         sfr(1'b0, 8'hC8, xbit[k]);
         arb(24'h000001 << xsrc[k]);
         sfr(1'b1, 8'hC8, 8'h00);
      end
      // Event and clear in one cycle: the set must win
      evt = 4'h1;
      {addr, wdat, wr} = {8'hC8, 8'h00, 1'b1};
      @(negedge clk_i);
      {evt, wr} = '0;
      sfr(1'b0, 8'hC8, 8'h80);
      sfr(1'b1, 8'hC8, 8'h00);
      // First two passes are fixed ties and the third has no request; the rest are random
      for (int n = 0; n < 200; n++) begin
         rnd = lfsr(rnd);
         sreq = n == 2 ? 24'h000000 : n < 2 ? 24'hFFFFFF : rnd[23:0];
         hi = n < 3 ? 6'(n << 5) : rnd[29:24];
         lo = n < 3 ? 6'(n << 5) : rnd[13:8];
         for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            en[k] = n < 3 ? 8'h3F : rnd[7:0];
         end
         sfr(1'b1, 8'hAC, {2'b00, hi});
         sfr(1'b1, 8'hB8, {2'b00, lo});
         arb(sreq & ~`GPIC_OWNED_MASK);
      end
      en = '{default: 8'h3F};
      sreq = 24'h000000;
      hi = 6'h20;
      lo = 6'h23;
      sfr(1'b1, 8'hAC, 8'h20);
      sfr(1'b1, 8'hB8, 8'h23);
      ib = 4'hA;
      sreq = 24'h000001;
      serve(5'h00);
      chk("active", 16'h0002, 16'(act));
      chk("pointer", 16'h0001, 16'(sp));
      chk("bank", 16'h00AA, 16'(bank));
      sreq = 24'h000003;
      repeat (4) @(negedge clk_i);
      chk("request", 16'h0000, 16'(req));
      ib = 4'h5;
      sreq = 24'h000023;
      serve(5'h05);
      chk("active", 16'h000A, 16'(act));
      chk("bank", 16'h0055, 16'(bank));
      sreq = 24'h000000;
      leave();
      chk("active", 16'h0002, 16'(act));
      chk("bank", 16'h00AA, 16'(bank));
      leave();
      chk("pointer", 16'h0000, 16'(sp));
      test_done();
   end
endmodule
